// [logic/bjs_params.svh]
// Constants of the branch, jump and skip control block.
// Assumes inclusion by bare name from the package only.
`ifndef BJS_PARAMS_SVH
`define BJS_PARAMS_SVH

// Program counter layout
`define BJS_PC_W          22
`define BJS_Z_W           16
`define BJS_EXT_W         6
`define BJS_OFS_W         12
`define BJS_PC_NARROW_W   16

// Status flag bit positions
`define BJS_FLAG_C        0
`define BJS_FLAG_Z        1
`define BJS_FLAG_N        2
`define BJS_FLAG_V        3
`define BJS_FLAG_S        4
`define BJS_FLAG_H        5
`define BJS_FLAG_T        6
`define BJS_FLAG_I        7

// Cycle counts per instruction
`define BJS_CYC_NOT_TAKEN   3'h1
`define BJS_CYC_TAKEN       3'h2
`define BJS_CYC_SKIP_ONE    3'h2
`define BJS_CYC_SKIP_TWO    3'h3
`define BJS_CYC_REL_JUMP    3'h2
`define BJS_CYC_ABS_JUMP    3'h3
`define BJS_CYC_IND_JUMP    3'h2
`define BJS_CYC_CALL_NARROW 3'h3
`define BJS_CYC_CALL_WIDE   3'h4
`define BJS_CYC_EXT_CALL    3'h4
`define BJS_CYC_RET_NARROW  3'h4
`define BJS_CYC_RET_WIDE    3'h5

// Register map, byte addresses on the bus
`define BJS_ADDR_W        8
`define BJS_OFS_EXT       8'h00
`define BJS_OFS_STATUS    8'h04
`define BJS_OFS_LASTPC    8'h08
`define BJS_EXT_RST       6'h00
`define BJS_STAT_BUSY     0
`define BJS_STAT_SKIP     1
`define BJS_STAT_IRQ      2

`endif

// [logic/bjs_pkg.sv]
// Types of the branch, jump and skip control block.
// Assumes the constants header sits beside it.
`include "bjs_params.svh"

package bjs_pkg;

  typedef enum logic [5:0] {
    OP_INDIRECT_JUMP,
    OP_EXTENDED_INDIRECT_JUMP,
    OP_INDIRECT_CALL,
    OP_EXTENDED_INDIRECT_CALL,
    OP_RELATIVE_JUMP,
    OP_ABSOLUTE_JUMP,
    OP_RELATIVE_SUBROUTINE_ENTRY,
    OP_SUBROUTINE_EXIT,
    OP_INTERRUPT_HANDLER_EXIT,
    OP_COMPARE_SKIP_EQUAL,
    OP_SKIP_REG_BIT_CLEAR,
    OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR,
    OP_SKIP_IO_BIT_SET,
    OP_BRANCH_FLAG_SET,
    OP_BRANCH_FLAG_CLEAR,
    OP_BRANCH_EQUAL,
    OP_BRANCH_NOT_EQUAL,
    OP_BRANCH_CARRY_ONE,
    OP_BRANCH_CARRY_ZERO,
    OP_BRANCH_SAME_OR_HIGHER,
    OP_BRANCH_UNSIGNED_LOWER,
    OP_BRANCH_MINUS,
    OP_BRANCH_PLUS,
    OP_BRANCH_SIGNED_GE,
    OP_BRANCH_SIGNED_LESS,
    OP_BRANCH_HALF_CARRY_ONE,
    OP_BRANCH_HALF_CARRY_ZERO,
    OP_BRANCH_TRANSFER_BIT_ONE,
    OP_BRANCH_TRANSFER_BIT_ZERO,
    OP_BRANCH_OVERFLOW_ONE,
    OP_BRANCH_OVERFLOW_ZERO,
    OP_BRANCH_IRQ_ON,
    OP_BRANCH_IRQ_OFF
  } bjs_op_t;

  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } bjs_state_t;

  typedef struct packed {
    bjs_state_t            state;
    logic [2:0]            cnt;
    logic [`BJS_PC_W-1:0]  pcNext;
    logic [`BJS_PC_W-1:0]  retAddr;
    logic                  pushRet;
    logic                  popRet;
    logic                  irqSet;
    logic                  skipped;
  } bjs_ctrl_t;

  typedef struct packed {
    logic [`BJS_EXT_W-1:0] ext;
    logic [31:0]           rdata;
    logic                  slvErr;
  } bjs_reg_t;

endpackage

// [logic/bjs_cond_eval.sv]
// Condition evaluator for skips and conditional branches.
// Assumes operands are stable while the instruction is offered.
`timescale 1ns/1ns

module bjs_cond_eval (
  // Instruction
  input  wire bjs_pkg::bjs_op_t op,
  input  wire logic [2:0]       flagSel,
  input  wire logic [2:0]       bitSel,
  // Operands
  input  wire logic [7:0]       flags,
  input  wire logic [7:0]       rdVal,
  input  wire logic [7:0]       rrVal,
  input  wire logic [7:0]       ioVal,
  // Result
  output logic                  condTrue,
  output logic                  isCond
);

  always_comb
  begin
    condTrue = 1'b0;
    isCond   = 1'b1;
    unique case (op)
      bjs_pkg::OP_COMPARE_SKIP_EQUAL:
        condTrue = (rdVal == rrVal);
      bjs_pkg::OP_SKIP_REG_BIT_CLEAR:
        condTrue = ~rrVal[bitSel];
      bjs_pkg::OP_SKIP_REG_BIT_SET:
        condTrue = rrVal[bitSel];
      bjs_pkg::OP_SKIP_IO_BIT_CLEAR:
        condTrue = ~ioVal[bitSel];
      bjs_pkg::OP_SKIP_IO_BIT_SET:
        condTrue = ioVal[bitSel];
      bjs_pkg::OP_BRANCH_FLAG_SET:
        condTrue = flags[flagSel];
      bjs_pkg::OP_BRANCH_FLAG_CLEAR:
        condTrue = ~flags[flagSel];
      bjs_pkg::OP_BRANCH_CARRY_ONE,
      bjs_pkg::OP_BRANCH_UNSIGNED_LOWER:
        condTrue = flags[`BJS_FLAG_C];
      bjs_pkg::OP_BRANCH_CARRY_ZERO,
      bjs_pkg::OP_BRANCH_SAME_OR_HIGHER:
        condTrue = ~flags[`BJS_FLAG_C];
      bjs_pkg::OP_BRANCH_SIGNED_GE:
        condTrue = ~(flags[`BJS_FLAG_N] ^ flags[`BJS_FLAG_V]);
      bjs_pkg::OP_BRANCH_SIGNED_LESS:
        condTrue = flags[`BJS_FLAG_N] ^ flags[`BJS_FLAG_V];
      bjs_pkg::OP_BRANCH_HALF_CARRY_ONE:
        condTrue = flags[`BJS_FLAG_H];
      bjs_pkg::OP_BRANCH_HALF_CARRY_ZERO:
        condTrue = ~flags[`BJS_FLAG_H];
      bjs_pkg::OP_BRANCH_TRANSFER_BIT_ONE:
        condTrue = flags[`BJS_FLAG_T];
      bjs_pkg::OP_BRANCH_TRANSFER_BIT_ZERO:
        condTrue = ~flags[`BJS_FLAG_T];
      bjs_pkg::OP_BRANCH_OVERFLOW_ONE:
        condTrue = flags[`BJS_FLAG_V];
      bjs_pkg::OP_BRANCH_OVERFLOW_ZERO:
        condTrue = ~flags[`BJS_FLAG_V];
      bjs_pkg::OP_BRANCH_IRQ_ON:
        condTrue = flags[`BJS_FLAG_I];
      bjs_pkg::OP_BRANCH_IRQ_OFF:
        condTrue = ~flags[`BJS_FLAG_I];
      bjs_pkg::OP_BRANCH_EQUAL:
        condTrue = flags[`BJS_FLAG_Z];
      bjs_pkg::OP_BRANCH_NOT_EQUAL:
        condTrue = ~flags[`BJS_FLAG_Z];
      bjs_pkg::OP_BRANCH_MINUS:
        condTrue = flags[`BJS_FLAG_N];
      bjs_pkg::OP_BRANCH_PLUS:
        condTrue = ~flags[`BJS_FLAG_N];
      default:
        isCond = 1'b0;
    endcase
  end

endmodule

// [logic/bjs_apb_regs.sv]
// APB register slave: extension register, status and last target.
// Assumes an APB master on the same clock; zero wait states.
`timescale 1ns/1ns

module bjs_apb_regs (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`BJS_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Block side
  input  wire logic [2:0]             statusBits,
  input  wire logic [`BJS_PC_W-1:0]   lastPc,
  output logic [`BJS_EXT_W-1:0]       jumpUpperExt
);

  bjs_pkg::bjs_reg_t q;
  bjs_pkg::bjs_reg_t d;

  function automatic logic mapped(input logic [`BJS_ADDR_W-1:0] a);
    mapped = (a == `BJS_OFS_EXT) || (a == `BJS_OFS_STATUS) ||
             (a == `BJS_OFS_LASTPC);
  endfunction

  always_comb
  begin
    d = q;
    // Read data and error are captured in the setup phase
    if (psel && !penable)
    begin
      d.slvErr = ~mapped(paddr);
      d.rdata  = 32'h0;
      if (!pwrite)
      begin
        unique case (paddr)
          `BJS_OFS_EXT:    d.rdata[`BJS_EXT_W-1:0] = q.ext;
          `BJS_OFS_STATUS: d.rdata[2:0] = statusBits;
          `BJS_OFS_LASTPC: d.rdata[`BJS_PC_W-1:0] = lastPc;
          default:         d.rdata = 32'h0;
        endcase
      end
    end
    if (psel && penable && pwrite && paddr == `BJS_OFS_EXT)
      d.ext = pwdata[`BJS_EXT_W-1:0];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      q.ext    <= `BJS_EXT_RST;
      q.rdata  <= 32'h0;
      q.slvErr <= 1'b0;
    end
    else
      q <= d;
  end

  assign pready       = 1'b1;
  assign prdata       = q.rdata;
  assign pslverr      = q.slvErr & psel & penable;
  assign jumpUpperExt = q.ext;

endmodule

// [logic/bjs_flow_ctrl.sv]
// Program-flow control: next PC and cycle count for jumps, calls,
// returns, skips and conditional branches.
// Assumes operands are valid while opValid is high and the core takes
// the result in the cycle resultValid is high.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns

module bjs_flow_ctrl #(
  parameter int PC_WIDTH = `BJS_PC_W
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // Instruction request
  input  wire logic                   opValid,
  output logic                        opReady,
  input  wire bjs_pkg::bjs_op_t       op,
  input  wire logic [2:0]             flagSel,
  input  wire logic [2:0]             bitSel,
  input  wire logic [`BJS_OFS_W-1:0]  offsetK,
  input  wire logic [`BJS_PC_W-1:0]   absTarget,
  input  wire logic                   nextTwoWord,
  // Core state
  input  wire logic [`BJS_PC_W-1:0]   pcIn,
  input  wire logic [`BJS_Z_W-1:0]    zPtr,
  input  wire logic [7:0]             rdVal,
  input  wire logic [7:0]             rrVal,
  input  wire logic [7:0]             ioVal,
  input  wire logic [7:0]             flags,
  input  wire logic [`BJS_PC_W-1:0]   stackPc,
  // Result
  output logic                        resultValid,
  output logic [`BJS_PC_W-1:0]        pcNext,
  output logic [`BJS_PC_W-1:0]        retAddr,
  output logic                        pushRet,
  output logic                        popRet,
  output logic                        setIrqEnable,
  output logic                        skipped,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`BJS_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr
);

  localparam logic [2:0] CycCall = (PC_WIDTH > `BJS_PC_NARROW_W) ?
                                   `BJS_CYC_CALL_WIDE :
                                   `BJS_CYC_CALL_NARROW;
  localparam logic [2:0] CycRet  = (PC_WIDTH > `BJS_PC_NARROW_W) ?
                                   `BJS_CYC_RET_WIDE :
                                   `BJS_CYC_RET_NARROW;

  bjs_pkg::bjs_ctrl_t        q;
  bjs_pkg::bjs_ctrl_t        d;
  logic                      condTrue;
  logic                      isCond;
  logic [`BJS_EXT_W-1:0]     jumpUpperExt;
  logic                      accept;
  logic [2:0]                cyc;
  logic [`BJS_PC_W-1:0]      target;

  function automatic logic [`BJS_PC_W-1:0] relTarget(
    input logic [`BJS_PC_W-1:0] pc,
    input logic [`BJS_OFS_W-1:0] k
  );
    logic [`BJS_PC_W-1:0] kExt;
    kExt = {{(`BJS_PC_W-`BJS_OFS_W){k[`BJS_OFS_W-1]}}, k};
    relTarget = pc + kExt + `BJS_PC_W'(1);
  endfunction

  function automatic logic [`BJS_PC_W-1:0] stepPc(
    input logic [`BJS_PC_W-1:0] pc,
    input logic [2:0]           n
  );
    stepPc = pc + `BJS_PC_W'(n);
  endfunction

  bjs_cond_eval u_cond (
    .op       (op),
    .flagSel  (flagSel),
    .bitSel   (bitSel),
    .flags    (flags),
    .rdVal    (rdVal),
    .rrVal    (rrVal),
    .ioVal    (ioVal),
    .condTrue (condTrue),
    .isCond   (isCond)
  );

  bjs_apb_regs u_regs (
    .clock        (clock),
    .rst          (rst),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .statusBits   ({q.irqSet, q.skipped, ~opReady}),
    .lastPc       (q.pcNext),
    .jumpUpperExt (jumpUpperExt)
  );

  assign opReady = (q.state == bjs_pkg::ST_IDLE);
  assign accept  = opValid & opReady;

  // Target and cycle count of the offered instruction
  always_comb
  begin
    target = stepPc(pcIn, 3'h1);
    cyc    = `BJS_CYC_NOT_TAKEN;
    unique case (op)
      bjs_pkg::OP_INDIRECT_JUMP:
      begin
        target = {{`BJS_EXT_W{1'b0}}, zPtr};
        cyc    = `BJS_CYC_IND_JUMP;
      end
      bjs_pkg::OP_EXTENDED_INDIRECT_JUMP:
      begin
        target = {jumpUpperExt, zPtr};
        cyc    = `BJS_CYC_IND_JUMP;
      end
      bjs_pkg::OP_INDIRECT_CALL:
      begin
        target = {{`BJS_EXT_W{1'b0}}, zPtr};
        cyc    = CycCall;
      end
      bjs_pkg::OP_EXTENDED_INDIRECT_CALL:
      begin
        target = {jumpUpperExt, zPtr};
        cyc    = `BJS_CYC_EXT_CALL;
      end
      bjs_pkg::OP_RELATIVE_JUMP:
      begin
        target = relTarget(pcIn, offsetK);
        cyc    = `BJS_CYC_REL_JUMP;
      end
      bjs_pkg::OP_ABSOLUTE_JUMP:
      begin
        target = absTarget;
        cyc    = `BJS_CYC_ABS_JUMP;
      end
      bjs_pkg::OP_RELATIVE_SUBROUTINE_ENTRY:
      begin
        target = relTarget(pcIn, offsetK);
        cyc    = CycCall;
      end
      bjs_pkg::OP_SUBROUTINE_EXIT,
      bjs_pkg::OP_INTERRUPT_HANDLER_EXIT:
      begin
        target = stackPc;
        cyc    = CycRet;
      end
      bjs_pkg::OP_COMPARE_SKIP_EQUAL,
      bjs_pkg::OP_SKIP_REG_BIT_CLEAR,
      bjs_pkg::OP_SKIP_REG_BIT_SET,
      bjs_pkg::OP_SKIP_IO_BIT_CLEAR,
      bjs_pkg::OP_SKIP_IO_BIT_SET:
      begin
        if (condTrue)
        begin
          // Skip over a one- or two-word instruction
          cyc    = nextTwoWord ? `BJS_CYC_SKIP_TWO
                               : `BJS_CYC_SKIP_ONE;
          target = stepPc(pcIn, cyc);
        end
      end
      default:
      begin
        if (isCond && condTrue)
        begin
          target = relTarget(pcIn, offsetK);
          cyc    = `BJS_CYC_TAKEN;
        end
      end
    endcase
  end

  always_comb
  begin
    d = q;
    unique case (q.state)
      bjs_pkg::ST_IDLE:
      begin
        if (accept)
        begin
          d.state   = bjs_pkg::ST_EXEC;
          d.cnt     = 3'(cyc - 3'h1);
          d.pcNext  = target;
          d.retAddr = stepPc(pcIn, 3'h1);
          d.pushRet = (op == bjs_pkg::OP_INDIRECT_CALL) ||
                      (op == bjs_pkg::OP_EXTENDED_INDIRECT_CALL) ||
                      (op == bjs_pkg::OP_RELATIVE_SUBROUTINE_ENTRY);
          d.popRet  = (op == bjs_pkg::OP_SUBROUTINE_EXIT) ||
                      (op == bjs_pkg::OP_INTERRUPT_HANDLER_EXIT);
          d.irqSet  = (op == bjs_pkg::OP_INTERRUPT_HANDLER_EXIT);
          d.skipped = isCond && condTrue &&
                      (op == bjs_pkg::OP_COMPARE_SKIP_EQUAL ||
                       op == bjs_pkg::OP_SKIP_REG_BIT_CLEAR ||
                       op == bjs_pkg::OP_SKIP_REG_BIT_SET ||
                       op == bjs_pkg::OP_SKIP_IO_BIT_CLEAR ||
                       op == bjs_pkg::OP_SKIP_IO_BIT_SET);
        end
      end
      bjs_pkg::ST_EXEC:
      begin
        if (q.cnt == 3'h0)
          d.state = bjs_pkg::ST_IDLE;
        else
          d.cnt = 3'(q.cnt - 3'h1);
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      q.state   <= bjs_pkg::ST_IDLE;
      q.cnt     <= 3'h0;
      q.pcNext  <= {`BJS_PC_W{1'b0}};
      q.retAddr <= {`BJS_PC_W{1'b0}};
      q.pushRet <= 1'b0;
      q.popRet  <= 1'b0;
      q.irqSet  <= 1'b0;
      q.skipped <= 1'b0;
    end
    else
      q <= d;
  end

  assign resultValid  = (q.state == bjs_pkg::ST_EXEC) && (q.cnt == 3'h0);
  assign pcNext       = q.pcNext;
  assign retAddr      = q.retAddr;
  assign pushRet      = q.pushRet;
  assign popRet       = q.popRet;
  assign setIrqEnable = resultValid & q.irqSet;
  assign skipped      = q.skipped;

  // Checks
  localparam int CallDly = (PC_WIDTH > `BJS_PC_NARROW_W) ? 4 : 3;
  localparam int RetDly  = (PC_WIDTH > `BJS_PC_NARROW_W) ? 5 : 4;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ind_jump_a: assert property (
    accept && op == bjs_pkg::OP_INDIRECT_JUMP |=>
      pcNext == {6'h00, $past(zPtr)} && !resultValid ##1 resultValid)
    else $error("indirect jump target or timing wrong");

  ext_jump_a: assert property (
    accept && op == bjs_pkg::OP_EXTENDED_INDIRECT_JUMP |=>
      pcNext == {$past(jumpUpperExt), $past(zPtr)} ##1 resultValid)
    else $error("extended indirect jump target wrong");

  ind_call_a: assert property (
    accept && op == bjs_pkg::OP_INDIRECT_CALL |->
      ##CallDly (resultValid && pcNext[21:16] == 6'h00 && pushRet))
    else $error("indirect call target or timing wrong");

  ext_call_a: assert property (
    accept && op == bjs_pkg::OP_EXTENDED_INDIRECT_CALL |->
      ##1 (!resultValid)[*3] ##1 resultValid)
    else $error("extended indirect call not four cycles");

  skip_equal_a: assert property (
    accept && op == bjs_pkg::OP_COMPARE_SKIP_EQUAL &&
    rdVal == rrVal && !nextTwoWord |=>
      pcNext == $past(pcIn) + 22'h2 && skipped ##1 resultValid)
    else $error("compare skip did not advance by two");

  reg_bit_a: assert property (
    accept && op == bjs_pkg::OP_SKIP_REG_BIT_SET &&
    !rrVal[bitSel] |-> ##1 (resultValid && !skipped &&
      pcNext == $past(pcIn) + 22'h1))
    else $error("register bit skip taken wrongly");

  io_bit_a: assert property (
    accept && op == bjs_pkg::OP_SKIP_IO_BIT_CLEAR && !ioVal[bitSel] &&
    nextTwoWord |=> pcNext == $past(pcIn) + 22'h3 ##2 resultValid)
    else $error("I/O bit skip over two words wrong");

  branch_taken_a: assert property (
    accept && isCond && condTrue && op == bjs_pkg::OP_BRANCH_FLAG_SET
    |=> pcNext == $past(pcIn) + {{10{$past(offsetK[11])}},
        $past(offsetK)} + 22'h1 ##1 resultValid)
    else $error("flag branch target wrong");

  branch_time_a: assert property (
    accept && op == bjs_pkg::OP_BRANCH_SIGNED_LESS &&
    (flags[2] == flags[3]) |=> resultValid && !skipped)
    else $error("untaken branch not one cycle");

  irq_exit_a: assert property (
    accept && op == bjs_pkg::OP_INTERRUPT_HANDLER_EXIT |->
      ##RetDly (setIrqEnable && pcNext == $past(stackPc, RetDly)))
    else $error("handler exit target or enable wrong");

  busy_hold_a: assert property (
    accept |=> !opReady until resultValid)
    else $error("new request taken while busy");

  taken_c: cover property (accept && isCond && condTrue &&
                           op == bjs_pkg::OP_BRANCH_EQUAL);
  skip_two_c: cover property (accept && nextTwoWord &&
                              op == bjs_pkg::OP_SKIP_IO_BIT_SET);
  irq_exit_c: cover property (setIrqEnable);
  ext_call_c: cover property (accept &&
                              op == bjs_pkg::OP_EXTENDED_INDIRECT_CALL);

endmodule

// [tb/bjs_core_model.sv]
// Core-side partner: program counter and stack top for the flow block.
// Assumes the block's result is taken in its resultValid cycle.
`timescale 1ns/1ns

module bjs_core_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Result from the block
  input  wire logic        resultValid,
  input  wire logic [21:0] pcNext,
  // Core state to the block
  output logic      [21:0] pcIn,
  output logic      [21:0] stackPc
);
  logic [21:0] pcQ;

  assign pcIn = pcQ;
  // Stack top kept apart from every jump target
  assign stackPc = pcQ ^ 22'h2aaaaa;

  always_ff @(posedge clock)
    if (rst)
      pcQ <= 22'h000100;
    else if (resultValid)
      pcQ <= pcNext;
endmodule

// [tb/bjs_flow_ctrl_bench.sv]
// Self-checking bench for the flow block: instruction and APB tasks.
// Assumes the core model supplies program counter and stack top.
`timescale 1ns/1ns

module bjs_flow_ctrl_bench;
  logic             clock, rst, opValid, nextTwoWord, p, pErr;
  logic             opReady, resultValid, pushRet, popRet;
  logic             setIrqEnable, skipped, psel, penable, pwrite;
  logic             pready, pslverr;
  logic [7:0]       paddr, rdVal, rrVal, flags, m;
  logic [2:0]       sel;
  logic [31:0]      pwdata, prdata, rd;
  logic [21:0]      pcIn, stackPc, pcNext, retAddr, pc, exp;
  bjs_pkg::bjs_op_t op;
  int               badCount, checksDone, cyc, n;
  int bitOf[20] = '{6, 6, 1, 1, 0, 0, 0, 0, 2, 2, 2, 2, 5, 5, 6, 6, 3, 3, 7, 7};
  int jk[9] = '{4, 5, 4, 5, 1, 6, 1, 7, 7};
  int jn[9] = '{2, 2, 4, 4, 2, 3, 4, 5, 5};

  bjs_flow_ctrl dut (.clock(clock), .rst(rst), .opValid(opValid),
    .opReady(opReady), .op(op), .flagSel(sel), .bitSel(sel),
    .offsetK(12'hffd), .absTarget(22'h3abcde), .nextTwoWord(nextTwoWord),
    .pcIn(pcIn), .zPtr(16'hbeef), .rdVal(rdVal), .rrVal(rrVal),
    .ioVal(rrVal), .flags(flags), .stackPc(stackPc),
    .resultValid(resultValid), .pcNext(pcNext), .retAddr(retAddr),
    .pushRet(pushRet), .popRet(popRet), .setIrqEnable(setIrqEnable),
    .skipped(skipped), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  bjs_core_model core (.clock(clock), .rst(rst), .resultValid(resultValid),
    .pcNext(pcNext), .pcIn(pcIn), .stackPc(stackPc));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic endSim;
    if (badCount == 0 && checksDone > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checksDone++;
    if (ok !== 1'b1)
    begin
      $display("[FAIL] %0t %s", $time, msg);
      badCount++;
    end
  endtask

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      badCount++;
      endSim;
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    pErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Kind of target: 0 pc+1, 1 pc+k+1, 2/3 skip, 4/5 Z, 6 absolute, 7 stack
  task automatic go(input bjs_pkg::bjs_op_t o, input logic [7:0] f,
    input logic [7:0] a, input logic [7:0] b, input logic [2:0] s,
    input logic t, input int kind, input int cnt);
    @(posedge clock);
    op <= o;
    flags <= f;
    rdVal <= a;
    rrVal <= b;
    sel <= s;
    nextTwoWord <= t;
    opValid <= 1'b1;
    @(negedge clock);
    pc = pcIn;
    case (kind)
      0: exp = pc + 22'h1;
      1: exp = pc - 22'h2;
      2: exp = pc + 22'h2;
      3: exp = pc + 22'h3;
      4: exp = {6'h00, 16'hbeef};
      5: exp = {6'h15, 16'hbeef};
      6: exp = 22'h3abcde;
      default: exp = stackPc;
    endcase
    @(posedge clock);
    opValid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end while (resultValid !== 1'b1 && n < 9);
    chk(n == cnt, "cycle count");
    chk(pcNext === exp, "next pc");
    chk(retAddr === pc + 22'h1, "return address");
    chk(pushRet === (int'(o) inside {2, 3, 6}), "push indication");
    chk(popRet === (int'(o) inside {7, 8}), "pop indication");
    chk(setIrqEnable === (int'(o) == 8), "irq enable pulse");
    chk(skipped === (kind == 2 || kind == 3), "skip indication");
  endtask

  initial
  begin
    {rst, opValid, nextTwoWord, psel, penable, pwrite} = 6'h21;
    {paddr, rdVal, rrVal, flags, sel} = '0;
    pwdata = '0;
    op = bjs_pkg::OP_INDIRECT_JUMP;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk(opReady === 1'b1 && pcNext === 22'h0, "reset outputs");
    apb(1'b0, 8'h00, 32'h0);
    chk(rd === 32'h0, "extension reset");
    apb(1'b1, 8'h00, 32'h15);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd === 32'h15 && pErr === 1'b0, "extension readback");
    apb(1'b1, 8'h04, 32'h7);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd === 32'h0, "status read only");
    apb(1'b0, 8'hfc, 32'h0);
    chk(pErr === 1'b1 && rd === 32'h0, "unmapped address");
    go(bjs_pkg::OP_COMPARE_SKIP_EQUAL, 8'h0, 8'h5a, 8'h5a, 3'h0, 1'b0, 2, 2);
    go(bjs_pkg::OP_COMPARE_SKIP_EQUAL, 8'h0, 8'h5a, 8'h5a, 3'h0, 1'b1, 3, 3);
    go(bjs_pkg::OP_COMPARE_SKIP_EQUAL, 8'h0, 8'h5a, 8'h5b, 3'h0, 1'b0, 0, 1);
    for (int j = 0; j < 4; j++)
    begin
      op = bjs_pkg::bjs_op_t'(10 + j);
      p = ~j[0];
      go(op, 8'h0, 8'h0, 8'hef, 3'h4, 1'b1, p ? 3 : 0, p ? 3 : 1);
      go(op, 8'h0, 8'h0, 8'h10, 3'h4, 1'b0, p ? 0 : 2, p ? 1 : 2);
    end
    for (int i = 0; i < 20; i++)
    begin
      p = (i inside {6, 7, 10, 11}) ? i[0] : ~i[0];
      m = 8'h1 << bitOf[i];
      op = bjs_pkg::bjs_op_t'(14 + i);
      go(op, p ? m : 8'h0, 8'h0, 8'h0, 3'(bitOf[i]), 1'b0, 1, 2);
      go(op, p ? 8'h0 : m, 8'h0, 8'h0, 3'(bitOf[i]), 1'b0, 0, 1);
    end
    for (int j = 0; j < 9; j++)
      go(bjs_pkg::bjs_op_t'(j), 8'h0, 8'h0, 8'h0, 3'h0, 1'b0, jk[j], jn[j]);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd === 32'(exp), "last target");
    apb(1'b0, 8'h04, 32'h0);
    chk(rd === 32'h4, "handler exit status");
    endSim;
  end
endmodule
